/* File: hw/mac_cfg_defines.vh */
// Offsets, field positions, reset values and timing counts of the block.
`ifndef MAC_CFG_DEFINES_VH
`define MAC_CFG_DEFINES_VH
`define OFF_IPG          12'h000
`define OFF_IPG_SET      12'h004
`define OFF_IPG_CLR      12'h008
`define OFF_IPG_INV      12'h00c
`define OFF_MCFG         12'h010
`define OFF_MCFG_SET     12'h014
`define OFF_MCFG_CLR     12'h018
`define OFF_MCFG_INV     12'h01c
`define OFF_TARGET_PHY_ADDRESS      12'h020
`define OFF_STATUS       12'h024
`define IPG_WMASK        32'h00007f7f
`define MCFG_WMASK       32'h0000803f
`define TARGET_PHY_ADDRESS_WMASK    32'h0000001f
`define IPG_RESET        32'h00000c12
`define MCFG_RESET       32'h00000020
`define TARGET_PHY_ADDRESS_RESET    32'h00000001
`define MCFG_RST_BIT     15
`define MCFG_SEL_HI      5
`define MCFG_SEL_LO      2
`define MCFG_PREAMBLE_SUPPRESS_BIT   1
`define MCFG_SCAN_BIT    0
`define IPG_P1_HI        14
`define IPG_P1_LO        8
`define IPG_P2_HI        6
`define IPG_P2_LO        0
`define PREAMBLE_BITS    6'd32
`define FRAME_BITS       6'd32
`endif

/* File: hw/mgmt_clk_div.v */
// Management clock divider: free-running MDC with enable pulses on edges.
`include "mac_cfg_defines.vh"

module mgmt_clk_div (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire [3:0] sel,
  input  wire       load,
  output reg        mdc_ff,
  output reg        rise_ff,
  output reg        fall_ff
);

  reg [4:0] half_ff;
  reg [4:0] cnt_ff;

  // Half period in system clocks for each divider code; codes 8 and above are 20.
  function [4:0] half_of;
    input [3:0] code;
    begin
      case (code)
        4'h0, 4'h1: half_of = 5'd2;
        4'h2:       half_of = 5'd3;
        4'h3:       half_of = 5'd4;
        4'h4:       half_of = 5'd5;
        4'h5:       half_of = 5'd7;
        4'h6:       half_of = 5'd10;
        4'h7:       half_of = 5'd14;
        default:    half_of = 5'd20;
      endcase
    end
  endfunction

  // Divisor is taken only when the engine says the link is between cycles.
  always @(posedge sys_clk) begin
    if (srst) begin
      half_ff <= 5'd20;
      cnt_ff  <= 5'd0;
      mdc_ff  <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
      if (load)
        half_ff <= half_of(sel);
      if (cnt_ff + 5'd1 >= half_ff) begin
        cnt_ff  <= 5'd0;
        mdc_ff  <= ~mdc_ff;
        rise_ff <= ~mdc_ff;
        fall_ff <= mdc_ff;
      end else begin
        cnt_ff <= cnt_ff + 5'd1;
      end
    end
  end

endmodule

/* File: hw/mac_ipg_mgmt.v */
// Gap deference timer, management config registers and MII scan-read engine.
`include "mac_cfg_defines.vh"

module mac_ipg_mgmt (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        crs_pin,
  input  wire        tx_pending,
  input  wire        slot_tick,
  output reg         tx_go,
  output reg         deferring,
  output reg         mdc,
  output reg         mdio_o,
  output reg         mdio_oe,
  input  wire        mdio_i,
  output reg  [15:0] scan_data,
  output reg  [4:0]  scan_addr,
  output reg         scan_valid
);

  // Gap timer states, one-hot.
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_GAP1 = 4'b0010;
  localparam [3:0] S_GAP2 = 4'b0100;
  localparam [3:0] S_SEND = 4'b1000;
  // Management engine states, one-hot.
  localparam [2:0] M_IDLE = 3'b001;
  localparam [2:0] M_PRE  = 3'b010;
  localparam [2:0] M_SHFT = 3'b100;

  // Register copies, gap timer, pin synchronisers and engine state.
  reg [31:0] ipg_ff;
  reg [31:0] mcfg_ff;
  reg [31:0] phy_ff;
  reg [3:0]  gst_ff;
  reg [6:0]  gcnt_ff;
  reg        crs_m_ff;
  reg        crs_s_ff;
  reg        mdi_m_ff;
  reg        mdi_s_ff;
  reg [2:0]  mst_ff;
  reg [5:0]  bit_ff;
  reg [31:0] frame_ff;
  reg [15:0] rdat_ff;
  reg [4:0]  cur_ff;
  reg        div_load_ff;
  reg [31:0] rmux;
  wire       mdc_int;
  wire       mdc_rise;
  wire       mdc_fall;
  wire       wr_acc;
  wire       wr_ok;
  wire       mrst;

  // Only halfword-aligned lane pairs or full words count as legal writes.
  assign wr_acc = psel & penable & pwrite;
  assign wr_ok  = (pstrb == 4'hf) | (pstrb == 4'h3) | (pstrb == 4'hc);
  assign mrst   = srst | mcfg_ff[`MCFG_RST_BIT];

  // Applies plain, set, clear or invert alias to a register under a mask.
  function [31:0] apply;
    input [31:0] cur;
    input [31:0] wd;
    input [3:0]  strb;
    input [1:0]  kind;
    input [31:0] wmask;
    reg   [31:0] lanes;
    reg   [31:0] m;
    begin
      lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      m = lanes & wmask;
      case (kind)
        2'd0:    apply = (cur & ~m) | (wd & m);
        2'd1:    apply = cur | (wd & m);
        2'd2:    apply = cur & ~(wd & m);
        default: apply = cur ^ (wd & m);
      endcase
    end
  endfunction

  // Synchronise the carrier and MDIO pins before anything reads them.
  always @(posedge sys_clk) begin
    if (srst) begin
      crs_m_ff <= 1'b0;
      crs_s_ff <= 1'b0;
      mdi_m_ff <= 1'b1;
      mdi_s_ff <= 1'b1;
    end else begin
      crs_m_ff <= crs_pin;
      crs_s_ff <= crs_m_ff;
      mdi_m_ff <= mdio_i;
      mdi_s_ff <= mdi_m_ff;
    end
  end

  // Register writes; the management reset bit survives its own reset effect.
  always @(posedge sys_clk) begin
    if (srst) begin
      ipg_ff  <= `IPG_RESET;
      mcfg_ff <= `MCFG_RESET;
      phy_ff  <= `TARGET_PHY_ADDRESS_RESET;
    end else if (wr_acc & wr_ok) begin
      case (paddr)
        `OFF_IPG, `OFF_IPG_SET, `OFF_IPG_CLR, `OFF_IPG_INV:
          ipg_ff <= apply(ipg_ff, pwdata, pstrb, paddr[3:2], `IPG_WMASK);
        `OFF_MCFG, `OFF_MCFG_SET, `OFF_MCFG_CLR, `OFF_MCFG_INV:
          mcfg_ff <= apply(mcfg_ff, pwdata, pstrb, paddr[3:2],
                           `MCFG_WMASK);
        `OFF_TARGET_PHY_ADDRESS:
          phy_ff <= apply(phy_ff, pwdata, pstrb, 2'd0, `TARGET_PHY_ADDRESS_WMASK);
        default: phy_ff <= phy_ff;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero; those above the status offset answer with an error.
  always @* begin
    rmux = 32'h00000000;
    case (paddr)
      `OFF_IPG, `OFF_IPG_SET, `OFF_IPG_CLR, `OFF_IPG_INV: rmux = ipg_ff;
      `OFF_MCFG, `OFF_MCFG_SET, `OFF_MCFG_CLR, `OFF_MCFG_INV:
        rmux = mcfg_ff;
      `OFF_TARGET_PHY_ADDRESS: rmux = phy_ff;
      `OFF_STATUS:  rmux = {26'h0000000, mst_ff != M_IDLE, deferring,
                            gst_ff};
      default:      rmux = 32'h00000000;
    endcase
  end

  // APB answer: no wait state, with data and ready both registered.
  always @(posedge sys_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `OFF_STATUS);
      if (psel & ~penable & ~pwrite)
        prdata <= rmux;
    end
  end

  // Deference timer counted in slot ticks.  Part one may defer to carrier;
  // once part one is over the send goes ahead whatever the medium does.
  always @(posedge sys_clk) begin
    if (srst) begin
      gst_ff    <= S_IDLE;
      gcnt_ff   <= 7'd0;
      tx_go     <= 1'b0;
      deferring <= 1'b0;
    end else begin
      tx_go <= 1'b0;
      case (gst_ff)
        S_IDLE: begin
          deferring <= crs_s_ff & tx_pending;
          if (tx_pending & ~crs_s_ff) begin
            gst_ff  <= S_GAP1;
            gcnt_ff <= 7'd0;
          end
        end
        S_GAP1: begin
          if (crs_s_ff) begin
            gst_ff    <= S_IDLE;
            deferring <= 1'b1;
          end else if (gcnt_ff >= ipg_ff[`IPG_P1_HI:`IPG_P1_LO]) begin
            gst_ff <= S_GAP2;
          end else if (slot_tick) begin
            gcnt_ff <= gcnt_ff + 7'd1;
          end
        end
        S_GAP2: begin
          deferring <= 1'b0;
          if (gcnt_ff >= ipg_ff[`IPG_P2_HI:`IPG_P2_LO]) begin
            gst_ff <= S_SEND;
          end else if (slot_tick) begin
            gcnt_ff <= gcnt_ff + 7'd1;
          end
        end
        S_SEND: begin
          // A request withdrawn while the gap ran is not sent.
          tx_go  <= tx_pending;
          gst_ff <= S_IDLE;
        end
        default: gst_ff <= S_IDLE;
      endcase
    end
  end

  // MDC and its edge pulses; the divisor is reloaded only while idle.
  mgmt_clk_div u_div (
    .sys_clk (sys_clk),
    .srst    (srst),
    .sel     (mcfg_ff[`MCFG_SEL_HI:`MCFG_SEL_LO]),
    .load    (div_load_ff),
    .mdc_ff  (mdc_int),
    .rise_ff (mdc_rise),
    .fall_ff (mdc_fall)
  );

  // Scan-read engine.  Data shifts out on MDC falling edges, read bits are
  // sampled on rising edges; a read frame is start, op, addresses and TA.
  always @(posedge sys_clk) begin
    if (mrst) begin
      mst_ff      <= M_IDLE;
      bit_ff      <= 6'd0;
      frame_ff    <= 32'h00000000;
      rdat_ff     <= 16'h0000;
      cur_ff      <= 5'd1;
      div_load_ff <= 1'b1;
      mdio_o      <= 1'b1;
      mdio_oe     <= 1'b0;
      scan_data   <= 16'h0000;
      scan_addr   <= 5'd0;
      scan_valid  <= 1'b0;
    end else begin
      scan_valid  <= 1'b0;
      div_load_ff <= 1'b0;
      case (mst_ff)
        M_IDLE: begin
          div_load_ff <= 1'b1;
          if (mdc_fall) begin
            frame_ff <= {4'b0110,
                         mcfg_ff[`MCFG_SCAN_BIT] ? cur_ff : phy_ff[4:0],
                         5'd0, 2'b11, 16'hffff};
            bit_ff  <= 6'd0;
            mdio_oe <= 1'b1;
            mdio_o  <= 1'b1;
            mst_ff  <= mcfg_ff[`MCFG_PREAMBLE_SUPPRESS_BIT] ? M_SHFT : M_PRE;
          end
        end
        M_PRE: begin
          if (mdc_fall) begin
            if (bit_ff == `PREAMBLE_BITS - 6'd1) begin
              bit_ff <= 6'd0;
              mst_ff <= M_SHFT;
            end else begin
              bit_ff <= bit_ff + 6'd1;
            end
          end
        end
        M_SHFT: begin
          if (mdc_fall) begin
            mdio_o   <= frame_ff[31];
            mdio_oe  <= (bit_ff < 6'd14);
            frame_ff <= {frame_ff[30:0], 1'b1};
            bit_ff   <= bit_ff + 6'd1;
          end
          if (mdc_rise & (bit_ff > 6'd16))
            rdat_ff <= {rdat_ff[14:0], mdi_s_ff};
          if (mdc_rise & (bit_ff == `FRAME_BITS)) begin
            scan_data  <= {rdat_ff[14:0], mdi_s_ff};
            scan_addr  <= mcfg_ff[`MCFG_SCAN_BIT] ? cur_ff : phy_ff[4:0];
            scan_valid <= 1'b1;
            mdio_oe    <= 1'b0;
            mst_ff     <= M_IDLE;
            if (mcfg_ff[`MCFG_SCAN_BIT] & (cur_ff < phy_ff[4:0]))
              cur_ff <= cur_ff + 5'd1;
            else
              cur_ff <= 5'd1;
          end
        end
        default: mst_ff <= M_IDLE;
      endcase
    end
  end

  // MDC leaves through a flop; it keeps running through engine reset.
  always @(posedge sys_clk) begin
    if (srst)
      mdc <= 1'b0;
    else
      mdc <= mdc_int;
  end

endmodule

/* File: bench/mac_ipg_mgmt_checker.sv */
// Port checks for the gap timer, config reads and management clock.
module mac_ipg_mgmt_checker (
  input logic        sys_clk,
  input logic        srst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        tx_pending,
  input logic        tx_go,
  input logic        mdc,
  input logic        scan_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no answer");
  property p_ipg;
    pready && !pwrite && paddr == 12'h000 |-> (prdata & 32'hffff8080) == 0;
  endproperty
  a_ipg: assert property (p_ipg) else $error("gap spare bit");
  property p_cfg;
    pready && !pwrite && paddr == 12'h010 |-> (prdata & 32'hffff7fc0) == 0;
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg spare bit");
  property p_go_one; tx_go |=> !tx_go; endproperty
  a_go_one: assert property (p_go_one) else $error("long go");
  property p_go_req; tx_go |-> $past(tx_pending); endproperty
  a_go_req: assert property (p_go_req) else $error("idle go");
  // The smallest divisor is four, so MDC is high for two clocks at least.
  property p_mdc_hi; $rose(mdc) |=> mdc; endproperty
  a_mdc_hi: assert property (p_mdc_hi) else $error("mdc short");
  property p_mdc_run; $rose(mdc) |-> ##[2:40] $fell(mdc); endproperty
  a_mdc_run: assert property (p_mdc_run) else $error("mdc stuck");
  property p_sv; scan_valid |=> !scan_valid; endproperty
  a_sv: assert property (p_sv) else $error("long valid");
endmodule

bind mac_ipg_mgmt mac_ipg_mgmt_checker u_mac_ipg_mgmt_checker (
  .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .tx_pending(tx_pending), .tx_go(tx_go), .mdc(mdc),
  .scan_valid(scan_valid));

/* File: bench/phy_model.sv */
// Management-link device that answers read frames with a tagged word.
module phy_model (
  input  logic mdc,
  input  logic mdio,
  output logic drv,
  output logic bit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] sh = 14'h3fff;
  logic [4:0]  cnt = 5'h0;
  logic [15:0] dat = 16'h0;
  wire  [13:0] w = {sh[12:0], mdio};
  // Start and read code are found with or without a preamble ahead.
  always @(posedge mdc) begin
    if (cnt != 5'h0) begin
      cnt <= (cnt == 5'h12) ? 5'h0 : cnt + 5'h1;
      sh <= 14'h3fff; // Data bits must never pass for a new start.
    end else begin
      sh <= w;
      if (w[13:10] == 4'h6) begin
        cnt <= 5'h1;
        dat <= {8'h5a, 3'h0, w[9:5]};
      end
    end
  end
  // Turnaround low, then sixteen data bits, then the line is let go.
  assign drv = cnt >= 5'h2;
  assign bit_o = (cnt == 5'h2) ? 1'h0 : dat[5'h12 - cnt];
endmodule

/* File: bench/mac_ipg_mgmt_test.sv */
// Self-checking bench for gap deference, config registers and scan reads.
module mac_ipg_mgmt_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'h0;
  logic        srst = 1'h1;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        crs_pin = 1'h0, tx_pending = 1'h0, slot_tick = 1'h0;
  logic        hold = 1'h0, pm = 1'h0, drv, bit_o;
  logic [1:0]  tcnt = 2'h0;
  logic [31:0] prdata, d;
  logic        pready, pslverr, tx_go, deferring, mdc, mdio_o, mdio_oe;
  logic [15:0] scan_data;
  logic [4:0]  scan_addr, ea;
  logic        scan_valid;
  logic [32:0] rq[$];
  logic [4:0]  aq[$];
  int          miscompares = 0, n_checks = 0, cyc = 0, seed = 81;
  int          len = 0, last_len = 0, dv[9] = '{4,4,6,8,10,14,20,28,40};
  time         t;
  // The line has a pull-up, so it reads high when nobody drives it.
  wire         mdio = mdio_oe ? mdio_o : (drv ? bit_o : 1'h1);

  mac_ipg_mgmt u_mac_ipg_mgmt (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crs_pin(crs_pin), .tx_pending(tx_pending), .slot_tick(slot_tick),
    .tx_go(tx_go), .deferring(deferring), .mdc(mdc), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .mdio_i(mdio), .scan_data(scan_data),
    .scan_addr(scan_addr), .scan_valid(scan_valid));
  phy_model u_phy_model (.mdc(mdc), .mdio(mdio), .drv(drv), .bit_o(bit_o));

  always #2 sys_clk = ~sys_clk;

  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [32:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // A request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] dd, input logic [3:0] s);
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] dd,
                    input logic [3:0] s = 4'hf);
    apb(1'h1, a, dd, s);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'h0, a, 32'h0, 4'h0);
  endtask

  task automatic frames(input int n);
    repeat (n) do @(posedge sys_clk); while (scan_valid !== 1'h1);
    @(posedge sys_clk);
  endtask

  // Carrier raised a given number of clocks after the send request.
  task automatic gap(input int at, input logic eg);
    logic go, df;
    go = 1'h0;
    df = 1'h0;
    // Let any gap started by the previous request run out first.
    repeat (80) @(posedge sys_clk);
    tx_pending <= 1'h1;
    for (int n = 0; n < 80; n++) begin
      @(posedge sys_clk);
      if (n == at) crs_pin <= 1'h1;
      if (deferring === 1'h1 && !go) df = 1'h1;
      if (tx_go === 1'h1) go = 1'h1;
      if (tx_go === 1'h1) tx_pending <= 1'h0;
    end
    chk("tx_go", eg, go);
    chk("deferring", !eg, df);
    crs_pin <= 1'h0;
    for (int n = 0; n < 200 && !go; n++) begin
      @(posedge sys_clk);
      if (tx_go === 1'h1) go = 1'h1;
    end
    tx_pending <= 1'h0;
    chk("retry", 1'h1, go);
  endtask

  // Gap units every fourth clock; the cycle count cuts a hang short.
  always @(posedge sys_clk) begin
    tcnt <= tcnt + 2'h1;
    slot_tick <= (tcnt == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      stop_test();
    end
  end

  // Each read result, and each scan result while notes remain, is matched against the oldest note.
  always @(posedge sys_clk) begin
    pm <= mdc;
    if (psel && penable && pready === 1'h1 && !pwrite)
      chk("prdata", rq.pop_front(), {pslverr, prdata});
    if (hold) chk("held", 2'h0, {scan_valid, mdio_oe});
    if (scan_valid === 1'h1) begin
      last_len <= len;
      len <= 0;
      if (aq.size() > 0) begin
        ea = aq.pop_front();
        chk("scan", {ea, 8'h5a, 3'h0, ea}, {scan_addr, scan_data});
      end
    end else if (mdc && !pm) len <= len + 1;
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'h0;
    rd(12'h000, 33'hc12);
    rd(12'h010, 33'h20);
    rd(12'h028, 33'h100000000);
    for (int i = 0; i < 4; i++) wr(12'h000, 32'hffffffff, 4'h1 << i);
    rd(12'h000, 33'hc12);
    wr(12'h000, 32'hffffffff);
    rd(12'h000, 33'h7f7f);
    wr(12'h010, 32'hffffffff);
    rd(12'h010, 33'h803f);
    wr(12'h000, 32'hffff0a10, 4'h3);
    wr(12'h004, 32'h0101);
    wr(12'h008, 32'h0200);
    wr(12'h00c, 32'h8003);
    rd(12'h000, 33'h0912);
    repeat (4) begin
      d = $random(seed);
      wr(12'h010, d);
      rd(12'h010, {1'h0, d & 32'h803f});
      wr(12'h000, d);
      rd(12'h000, {1'h0, d & 32'h7f7f});
    end
    $display("test registers done");
    wr(12'h000, 32'h040c);
    gap(1, 1'h0);
    gap(30, 1'h1);
    wr(12'h000, 32'h0c12);
    $display("test deference done");
    wr(12'h020, 32'h3);
    wr(12'h010, 32'h8001);
    repeat (4) @(posedge sys_clk);
    hold <= 1'h1;
    repeat (300) @(posedge sys_clk);
    rd(12'h024, 33'h1);
    hold <= 1'h0;
    aq = '{5'h1, 5'h2, 5'h3, 5'h1};
    wr(12'h010, 32'h0019);
    frames(4);
    chk("scan left", 33'h0, aq.size());
    chk("preamble", 33'h1, last_len >= 64);
    wr(12'h010, 32'h801a);
    aq = '{5'h3, 5'h3, 5'h3};
    wr(12'h010, 32'h001a);
    frames(3);
    chk("repeat left", 33'h0, aq.size());
    chk("no preamble", 33'h1, last_len < 64);
    $display("test scan done");
    foreach (dv[i]) begin
      wr(12'h010, {26'h0, 4'(i), 2'h2});
      frames(2);
      @(posedge mdc);
      t = $time;
      @(posedge mdc);
      chk("divisor", dv[i], ($time - t) / 4);
    end
    $display("test divider done");
    stop_test();
  end
endmodule
